// *** usr_consts.vh ***
// Purpose: constants of the serial transceiver register block
// Assumes: included by usr_top.v only
// Notes: register offsets are indexes; the byte address is four times the index
`ifndef USR_CONSTS_VH
`define USR_CONSTS_VH
// register indexes and their byte addresses
`define USR_IDX_STAT_A 8'hC0
`define USR_IDX_CTRL_B 8'hC1
`define USR_IDX_FRAME 8'hC2
`define USR_IDX_BAUD 8'hC4
`define USR_IDX_DATA 8'hC6
`define USR_BYTE_ADDR(i) {2'h0, (i), 2'h0}
`define USR_ADDR_W 12
// reset values
`define USR_RST_STAT_A 8'h20
`define USR_RST_CTRL_B 8'h00
`define USR_RST_FRAME 8'h06
`define USR_RST_BAUD 12'h000
// status a fields
`define USR_A_RXC 7
`define USR_A_TXC 6
`define USR_A_UDRE 5
`define USR_A_FE 4
`define USR_A_DOR 3
`define USR_A_UPE 2
`define USR_A_U2X 1
`define USR_A_MPCM 0
// control b fields
`define USR_B_RXCIE 7
`define USR_B_TXCIE 6
`define USR_B_UDRIE 5
`define USR_B_RXEN 4
`define USR_B_TXEN 3
`define USR_B_SZ2 2
`define USR_B_RXB8 1
`define USR_B_TXB8 0
// frame control fields
`define USR_C_MODE_HI 7
`define USR_C_MODE_LO 6
`define USR_C_PAR_HI 5
`define USR_C_PAR_LO 4
`define USR_C_SBS 3
`define USR_C_SZ1 2
`define USR_C_SZ0 1
`define USR_C_POL 0
// modes, parity codes and character size codes
`define USR_MODE_ASYNC 2'h0
`define USR_MODE_SYNC 2'h1
`define USR_MODE_SPI 2'h3
`define USR_PAR_ODD 2'h3
`define USR_SZ_NINE 3'h7
// oversampling divisors
`define USR_OVS_NORMAL 5'h10
`define USR_OVS_DOUBLE 5'h08
// bus answers
`define USR_RESP_OKAY 2'h0
`define USR_RESP_SLVERR 2'h2
`endif

// *** usr_line_peer.sv ***
// Purpose: remote serial station on the line
// Assumes: frames are 11 bits, first bit in bit 0
// Notes: only 8 data bits of each device frame are decoded
`timescale 1ns/1ps
`default_nettype none
module usr_line_peer (
	// clock and bit length
	input wire logic clk_in,
	input wire logic [4:0] bit_clks_in,
	// frame to the device
	input wire logic [10:0] frame_in,
	input wire logic send_in,
	output logic busy_out,
	output logic line_out,
	// characters from the device
	input wire logic tx_line_in,
	input wire logic tx_oe_in,
	output logic [7:0] got_byte_out,
	output logic [7:0] got_count_out
);
	int i;
	int j;
	logic [7:0] b;
	// line rests high between frames
	initial begin
		busy_out = 1'b0;
		line_out = 1'b1;
		got_byte_out = 8'h00;
		got_count_out = 8'h00;
	end
	// shift one frame out, one bit time per bit
	always @(posedge clk_in) begin
		if (send_in && !busy_out) begin
			busy_out <= 1'b1;
			for (i = 0; i < 11; i++) begin
				line_out <= frame_in[i];
				repeat (bit_clks_in) @(posedge clk_in);
			end
			busy_out <= 1'b0;
		end
	end
	// sample mid bit, least significant bit first
	always begin
		@(negedge tx_line_in);
		if (tx_oe_in) begin
			repeat (bit_clks_in + bit_clks_in / 2) @(posedge clk_in);
			for (j = 0; j < 8; j++) begin
				b[j] = tx_line_in;
				repeat (bit_clks_in) @(posedge clk_in);
			end
			got_byte_out = b;
			got_count_out = got_count_out + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** usr_top.v ***
// Purpose: register interface and serial engine of a uart/usart transceiver
// Assumes: one clock, AXI4-Lite register access, line inputs are asynchronous
// Notes: master spi mode only disables its reserved fields; its timing is not built
// What this block does
// R1 - one data location: writes transmit, reads receive
// R2 - short characters: high bits ignored, read zero
// R3 - data write ignored while buffer not empty
// R4 - buffered data moves into empty shifter, sent
// R5 - two-entry receive fifo advances on data read
// R6 - receive done tracks unread data; off flushes
// R7 - transmit done on idle; cleared by service/write-one
// R8 - buffer-empty flag set when writable, after reset
// R9 - frame error reports head character stop bit
// R10 - overrun: fifo full, char waiting, new start
// R11 - parity error if checked and mismatched
// R12 - software writes zero to error bits
// R13 - double speed divides by eight, async only
// R14 - multidrop drops frames without address information
// R15 - interrupt needs own enable, global, flag
// R16 - receiver owns pin; off clears errors, fifo
// R17 - transmitter off waits for empty shifter, buffer
// R18 - software reads ninth bit before low bits
// R19 - software writes ninth bit before low bits
// R20 - mode field: async, sync, reserved, spi
// R21 - spi mode disables error, speed, ninth fields
// R22 - frame control resets to 0x06
// R23 - size codes five to eight, nine
// R24 - parity field: off, reserved, even, odd
// R25 - stop select sets transmitted stop bits
// R26 - sync polarity picks change and sample edges
// R27 - error flags and ninth bit stored per entry
//
// Register access over AXI4-Lite was decided locally.
`include "usr_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module usr_top (
	// clock and reset
	input wire CLK_IN,
	input wire NRST_IN,
	// axi4-lite write channels
	input wire [`USR_ADDR_W-1:0] S_AXI_AWADDR_IN,
	input wire S_AXI_AWVALID_IN,
	output wire S_AXI_AWREADY_OUT,
	input wire [31:0] S_AXI_WDATA_IN,
	input wire [3:0] S_AXI_WSTRB_IN,
	input wire S_AXI_WVALID_IN,
	output wire S_AXI_WREADY_OUT,
	output reg [1:0] S_AXI_BRESP_OUT,
	output reg S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	// axi4-lite read channels
	input wire [`USR_ADDR_W-1:0] S_AXI_ARADDR_IN,
	input wire S_AXI_ARVALID_IN,
	output wire S_AXI_ARREADY_OUT,
	output reg [31:0] S_AXI_RDATA_OUT,
	output reg [1:0] S_AXI_RRESP_OUT,
	output reg S_AXI_RVALID_OUT,
	input wire S_AXI_RREADY_IN,
	// cpu side interrupt handshake
	input wire GLOBAL_IRQ_EN_IN,
	input wire TX_DONE_SERVICED_IN,
	output wire RX_DONE_IRQ_OUT,
	output wire TX_DONE_IRQ_OUT,
	output wire TX_EMPTY_IRQ_OUT,
	// line pins
	input wire RX_LINE_IN,
	output reg TX_LINE_OUT,
	output wire TX_LINE_OE_OUT,
	output wire RX_LINE_OWN_OUT,
	output reg SYNC_CLOCK_PIN_OUT,
	output wire SYNC_CLOCK_PIN_OE_OUT
);
	// state codes of the receiver
	localparam RX_IDLE = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_BITS = 2'h2;
	// decode by register index so that no address bit is shifted out of the compare
	localparam [7:0] A_ADDR = `USR_IDX_STAT_A;
	localparam [7:0] B_ADDR = `USR_IDX_CTRL_B;
	localparam [7:0] C_ADDR = `USR_IDX_FRAME;
	localparam [7:0] BAUD_ADDR = `USR_IDX_BAUD;
	localparam [7:0] DATA_ADDR = `USR_IDX_DATA;
	localparam [7:0] RST_A = `USR_RST_STAT_A;

	// software visible state
	reg txc_r, u2x_r, mpcm_r;
	reg [7:0] ctrl_b_r;
	reg [7:0] frame_r;
	reg [11:0] baud_r;
	// transmit side
	reg [8:0] tx_hold_buffer_r;
	reg tx_hold_full_r, tx_busy_r, txen_act_r;
	reg [12:0] tx_sr_r;
	reg [3:0] tx_left_r;
	reg [4:0] tx_div_r;
	// receive side: fifo entry is {dor, pe, fe, ninth, data}
	reg [11:0] rx_hold_buffer_r [0:1];
	reg [1:0] rx_cnt_r;
	reg [11:0] rx_pend_r;
	reg rx_pend_full_r;
	reg [1:0] rx_st_r;
	reg [4:0] rx_div_r;
	reg [3:0] rx_idx_r;
	reg [10:0] rx_sr_r;
	reg rx_m_r, rx_s_r;
	// baud generator and sync clock
	reg [11:0] brg_r;
	reg xck_r;

	// decoded frame settings; spi mode forces its reserved fields off
	wire [1:0] mode = frame_r[`USR_C_MODE_HI:`USR_C_MODE_LO]; // R20
	wire spi = (mode == `USR_MODE_SPI);
	wire sync_m = (mode == `USR_MODE_SYNC) | spi;
	wire [2:0] sz = {ctrl_b_r[`USR_B_SZ2] & ~spi, frame_r[`USR_C_SZ1], frame_r[`USR_C_SZ0]};
	wire nine = (sz == `USR_SZ_NINE); // R23
	// reserved size codes fall back to eight bits
	wire [3:0] nbits = nine ? 4'h9 : (sz[2] ? 4'h8 : {2'h0, sz[1:0]} + 4'h5); // R23
	wire pen = frame_r[`USR_C_PAR_HI] & ~spi; // R24 R21
	wire podd = (frame_r[`USR_C_PAR_HI:`USR_C_PAR_LO] == `USR_PAR_ODD); // R24
	wire two_stop = frame_r[`USR_C_SBS] & ~spi; // R25
	wire [4:0] ovs = (u2x_r & ~sync_m) ? `USR_OVS_DOUBLE : `USR_OVS_NORMAL; // R13 R21
	wire rxen = ctrl_b_r[`USR_B_RXEN];
	wire [8:0] mask = ~(9'h1FF << nbits);
	wire [11:0] head = rx_hold_buffer_r[0];
	wire rxc = (rx_cnt_r != 2'h0); // R6
	wire udre = ~tx_hold_full_r; // R8

	// baud ticks; sync mode uses both edges of the generated clock
	wire tick = (brg_r == 12'h000);
	wire tx_edge = tick & (xck_r == frame_r[`USR_C_POL]); // R26
	wire rx_edge = tick & (xck_r != frame_r[`USR_C_POL]); // R26
	wire tx_step = sync_m ? tx_edge : (tick & (tx_div_r == 5'h00));

	// bus handshake: address and data are taken together
	wire wr_go = S_AXI_AWVALID_IN & S_AXI_WVALID_IN & ~S_AXI_BVALID_OUT;
	wire rd_go = S_AXI_ARVALID_IN & ~S_AXI_RVALID_OUT;
	wire [7:0] waddr = S_AXI_AWADDR_IN[9:2];
	wire [7:0] raddr = S_AXI_ARADDR_IN[9:2];
	wire wr_hi_ok = (S_AXI_AWADDR_IN[`USR_ADDR_W-1:10] == 2'h0);
	wire rd_hi_ok = (S_AXI_ARADDR_IN[`USR_ADDR_W-1:10] == 2'h0);
	wire wr_en = wr_go & S_AXI_WSTRB_IN[0] & wr_hi_ok;
	wire [7:0] wd = S_AXI_WDATA_IN[7:0];
	wire wr_a = wr_en & (waddr == A_ADDR);
	wire wr_data = wr_en & (waddr == DATA_ADDR);
	wire rd_data = rd_go & rd_hi_ok & (raddr == DATA_ADDR);
	assign S_AXI_AWREADY_OUT = wr_go;
	assign S_AXI_WREADY_OUT = wr_go;
	assign S_AXI_ARREADY_OUT = rd_go;

	// interrupt requests
	assign RX_DONE_IRQ_OUT = ctrl_b_r[`USR_B_RXCIE] & GLOBAL_IRQ_EN_IN & rxc; // R15
	assign TX_DONE_IRQ_OUT = ctrl_b_r[`USR_B_TXCIE] & GLOBAL_IRQ_EN_IN & txc_r; // R15
	assign TX_EMPTY_IRQ_OUT = ctrl_b_r[`USR_B_UDRIE] & GLOBAL_IRQ_EN_IN & udre; // R15
	// pin ownership
	assign RX_LINE_OWN_OUT = rxen; // R16
	assign TX_LINE_OE_OUT = txen_act_r; // R17
	assign SYNC_CLOCK_PIN_OE_OUT = sync_m & txen_act_r;

	// status register a as read: error bits come from the fifo head
	wire [7:0] stat_a = {rxc, txc_r, udre, head[9] & rxc & ~spi, head[11] & rxc & ~spi,
		head[10] & rxc & ~spi, u2x_r, mpcm_r}; // R9 R10 R11 R21

	// write path and bus responses
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= `USR_RESP_OKAY;
			u2x_r <= RST_A[`USR_A_U2X];
			mpcm_r <= 1'b0;
			ctrl_b_r <= `USR_RST_CTRL_B;
			frame_r <= `USR_RST_FRAME; // R22
			baud_r <= `USR_RST_BAUD;
		end else begin
			if (wr_go) begin
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= (wr_hi_ok & (waddr == A_ADDR | waddr == B_ADDR |
					waddr == C_ADDR | waddr == BAUD_ADDR | waddr == DATA_ADDR)) ?
					`USR_RESP_OKAY : `USR_RESP_SLVERR;
			end else if (S_AXI_BREADY_IN) begin
				S_AXI_BVALID_OUT <= 1'b0;
			end
			// error bits in a write are ignored, software is expected to send zero
			if (wr_a) begin // R12
				u2x_r <= wd[`USR_A_U2X]; // R13
				mpcm_r <= wd[`USR_A_MPCM]; // R14
			end
			// received ninth bit is read only
			if (wr_en & (waddr == B_ADDR))
				ctrl_b_r <= {wd[7:2], 1'b0, wd[`USR_B_TXB8]};
			if (wr_en & (waddr == C_ADDR))
				frame_r <= wd;
			if (wr_en & (waddr == BAUD_ADDR))
				baud_r <= S_AXI_WSTRB_IN[1] ? S_AXI_WDATA_IN[11:0] : {baud_r[11:8], wd};
		end
	end

	// read path; reading the data location pops the fifo
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h00000000;
			S_AXI_RRESP_OUT <= `USR_RESP_OKAY;
		end else if (rd_go) begin
			S_AXI_RVALID_OUT <= 1'b1;
			S_AXI_RRESP_OUT <= `USR_RESP_OKAY;
			if (!rd_hi_ok)
				S_AXI_RRESP_OUT <= `USR_RESP_SLVERR;
			case (raddr)
				A_ADDR: S_AXI_RDATA_OUT <= {24'h000000, stat_a};
				B_ADDR: S_AXI_RDATA_OUT <= {24'h000000, ctrl_b_r[7:2],
					head[8] & rxc & ~spi, ctrl_b_r[0]}; // R27
				C_ADDR: S_AXI_RDATA_OUT <= {24'h000000, frame_r};
				BAUD_ADDR: S_AXI_RDATA_OUT <= {20'h00000, baud_r};
				DATA_ADDR: S_AXI_RDATA_OUT <= {24'h000000, head[7:0] & mask[7:0]}; // R1 R2
				default: begin
					S_AXI_RDATA_OUT <= 32'h00000000;
					S_AXI_RRESP_OUT <= `USR_RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RREADY_IN) begin
			S_AXI_RVALID_OUT <= 1'b0;
		end
	end

	// baud generator and synchronous clock output
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			brg_r <= 12'h000;
			xck_r <= 1'b0;
			SYNC_CLOCK_PIN_OUT <= 1'b0;
		end else begin
			brg_r <= tick ? baud_r : brg_r - 12'h001;
			if (tick)
				xck_r <= ~xck_r;
			SYNC_CLOCK_PIN_OUT <= sync_m & xck_r;
		end
	end

	// transmit frame image: start, data lsb first, parity, stop bits as ones
	reg [12:0] tx_img;
	reg tx_par;
	integer i;
	always @* begin
		tx_img = 13'h1FFE;
		tx_par = podd;
		for (i = 0; i < 9; i = i + 1) begin
			if (i < nbits) begin
				tx_img[i + 1] = tx_hold_buffer_r[i]; // R2
				tx_par = tx_par ^ tx_hold_buffer_r[i];
			end else if (i == nbits) begin
				tx_img[i + 1] = pen ? tx_par : 1'b1; // R24
			end
		end
		// nine data bits put parity past the loop's reach; other sizes keep stop ones
		if (nbits == 4'h9)
			tx_img[10] = pen ? tx_par : 1'b1;
	end

	// transmitter: hold buffer, shifter, done flag and enable hand-back
	wire load = tx_hold_full_r & ~tx_busy_r & ctrl_b_r[`USR_B_TXEN]; // R4
	wire [3:0] tx_len = nbits + {3'h0, pen} + {3'h0, two_stop} + 4'h2;
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			tx_hold_buffer_r <= 9'h000;
			tx_hold_full_r <= 1'b0;
			tx_busy_r <= 1'b0;
			tx_sr_r <= 13'h1FFF;
			tx_left_r <= 4'h0;
			tx_div_r <= 5'h00;
			txen_act_r <= 1'b0;
			txc_r <= 1'b0;
			TX_LINE_OUT <= 1'b1;
		end else begin
			// a write while the buffer is full leaves it untouched
			if (wr_data & udre) begin // R3 R1
				tx_hold_buffer_r <= {ctrl_b_r[`USR_B_TXB8] & ~spi, wd}; // R19
				tx_hold_full_r <= 1'b1; // R8
			end else if (load) begin
				tx_hold_full_r <= 1'b0;
			end
			if (tick)
				tx_div_r <= (tx_div_r == 5'h00) ? ovs - 5'h01 : tx_div_r - 5'h01;
			if (load) begin
				tx_busy_r <= 1'b1;
				tx_sr_r <= tx_img;
				tx_left_r <= tx_len;
			end else if (tx_busy_r & tx_step) begin
				TX_LINE_OUT <= tx_sr_r[0];
				tx_sr_r <= {1'b1, tx_sr_r[12:1]};
				tx_left_r <= tx_left_r - 4'h1;
				if (tx_left_r == 4'h0)
					tx_busy_r <= 1'b0;
			end else if (!tx_busy_r) begin
				TX_LINE_OUT <= 1'b1;
			end
			// done flag: hardware set wins over service and write-one clear
			if (tx_busy_r & tx_step & (tx_left_r == 4'h0) & ~tx_hold_full_r)
				txc_r <= 1'b1; // R7
			else if (TX_DONE_SERVICED_IN | (wr_a & wd[`USR_A_TXC]))
				txc_r <= 1'b0; // R7
			// disabling waits until shifter and buffer are both empty
			if (ctrl_b_r[`USR_B_TXEN])
				txen_act_r <= 1'b1;
			else if (~tx_busy_r & ~tx_hold_full_r)
				txen_act_r <= 1'b0; // R17
		end
	end

	// two-flop synchroniser on the receive pin
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rx_m_r <= 1'b1;
			rx_s_r <= 1'b1;
		end else begin
			rx_m_r <= RX_LINE_IN;
			rx_s_r <= rx_m_r;
		end
	end

	// completed character, assembled from the receive shifter
	wire rx_strobe = sync_m ? rx_edge : (tick & (rx_div_r == 5'h00));
	wire [3:0] rx_len = nbits + {3'h0, pen} + 4'h1;
	wire rx_done = (rx_st_r == RX_BITS) & rx_strobe & (rx_idx_r == rx_len - 4'h1);
	wire [10:0] rx_full = rx_sr_r | ({10'h000, rx_s_r} << rx_idx_r);
	wire [8:0] rx_dat = rx_full[8:0] & mask; // R2
	wire rx_pbit = rx_full[nbits];
	wire rx_stop = rx_full[rx_len - 4'h1];
	wire rx_pe = pen & (^rx_dat ^ podd ^ rx_pbit); // R11
	// address information is the ninth bit, or the top data bit otherwise
	wire rx_addr = nine ? rx_dat[8] : rx_dat[nbits - 4'h1];
	wire rx_keep = ~(mpcm_r & ~spi) | rx_addr; // R14
	wire [11:0] rx_ent = {1'b0, rx_pe, ~rx_stop, rx_dat}; // R9 R27
	wire pop = rd_data & rxc; // R5
	wire push_new = rx_done & rx_keep;
	// overrun: fifo full, character waiting, new start seen
	// uses the same start test as the receiver, else the start is missed
	wire rx_start_seen = sync_m ? (rx_strobe & ~rx_s_r) : (tick & ~rx_s_r);
	wire ovr = (rx_st_r == RX_IDLE) & rx_start_seen & rx_pend_full_r &
		(rx_cnt_r == 2'h2) & ~pop; // R10

	// receiver: start detect, bit sampling, pending slot and fifo
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rx_st_r <= RX_IDLE;
			rx_div_r <= 5'h00;
			rx_idx_r <= 4'h0;
			rx_sr_r <= 11'h000;
			rx_cnt_r <= 2'h0;
			rx_pend_r <= 12'h000;
			rx_pend_full_r <= 1'b0;
			rx_hold_buffer_r[0] <= 12'h000;
			rx_hold_buffer_r[1] <= 12'h000;
		end else if (!rxen) begin
			// switching off flushes data and error flags
			rx_st_r <= RX_IDLE; // R16
			rx_cnt_r <= 2'h0; // R6
			rx_pend_full_r <= 1'b0;
		end else begin
			if (tick)
				rx_div_r <= (rx_div_r == 5'h00) ? ovs - 5'h01 : rx_div_r - 5'h01;
			case (rx_st_r)
				RX_IDLE: begin
					if (rx_start_seen) begin
						rx_st_r <= sync_m ? RX_BITS : RX_START;
						rx_div_r <= (ovs >> 1) - 5'h01;
						rx_idx_r <= 4'h0;
						rx_sr_r <= 11'h000;
					end
				end
				RX_START: begin
					// a start bit gone high at mid point was a glitch
					if (rx_strobe)
						rx_st_r <= rx_s_r ? RX_IDLE : RX_BITS;
				end
				RX_BITS: begin
					if (rx_strobe) begin
						rx_sr_r <= rx_full;
						rx_idx_r <= rx_idx_r + 4'h1;
						if (rx_done)
							rx_st_r <= RX_IDLE;
					end
				end
				default: rx_st_r <= RX_IDLE;
			endcase
			if (ovr)
				rx_pend_r[11] <= 1'b1; // R10
			// fifo update: pop first, then pending slot, then new character
			case ({pop, rx_pend_full_r, push_new})
				3'b100, 3'b101: begin
					rx_hold_buffer_r[0] <= rx_hold_buffer_r[1];
					if (push_new & (rx_cnt_r == 2'h2))
						rx_hold_buffer_r[1] <= rx_ent;
					else if (push_new)
						rx_hold_buffer_r[0] <= rx_ent;
					rx_cnt_r <= rx_cnt_r - 2'h1 + {1'b0, push_new};
				end
				3'b110, 3'b111: begin
					rx_hold_buffer_r[0] <= rx_hold_buffer_r[1];
					rx_hold_buffer_r[1] <= rx_pend_r;
					rx_pend_full_r <= push_new;
					rx_pend_r <= rx_ent;
				end
				3'b001, 3'b011: begin
					if (rx_cnt_r == 2'h2) begin
						// a second waiting character is lost
						rx_pend_full_r <= 1'b1;
						if (!rx_pend_full_r)
							rx_pend_r <= rx_ent;
					end else begin
						rx_hold_buffer_r[rx_cnt_r[0]] <= rx_ent; // R5 R27
						rx_cnt_r <= rx_cnt_r + 2'h1;
					end
				end
				default: rx_cnt_r <= rx_cnt_r;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** usr_top_bench.sv ***
// Purpose: register level tests of the serial block
// Assumes: baud divisor 0, so a bit lasts 16 clocks, 8 at double speed
// Notes: bready and rready stay high, which the bus allows
`timescale 1ns/1ps
`default_nettype none
module usr_top_bench;
	localparam logic [11:0] RA = 12'h300, RB = 12'h304, RC = 12'h308, RD = 12'h318;
	logic clk, nrst, awv, wv, arv, gie, svc, br, rr, snd, dor;
	logic [11:0] awa, ara;
	logic [31:0] wd, v;
	logic [3:0] ws;
	logic [1:0] r;
	logic [4:0] bclk;
	logic [10:0] frm;
	logic [31:0] modes [3] = '{32'h06, 32'h46, 32'hC6};
	logic [7:0] ov [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	wire logic awr, bv, arr, rv, irq_rx, irq_txc, irq_txe, rxl, txl, txoe, own, busy;
	wire logic [31:0] rdat;
	wire logic [1:0] bresp, rresp;
	wire logic [7:0] gb, gc;
	int bad_count, cmp_count;
	usr_top usr_top_inst (.CLK_IN(clk), .NRST_IN(nrst), .S_AXI_AWADDR_IN(awa),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
		.S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
		.S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
		.S_AXI_RREADY_IN(rr), .GLOBAL_IRQ_EN_IN(gie), .TX_DONE_SERVICED_IN(svc),
		.RX_DONE_IRQ_OUT(irq_rx), .TX_DONE_IRQ_OUT(irq_txc), .TX_EMPTY_IRQ_OUT(irq_txe),
		.RX_LINE_IN(rxl), .TX_LINE_OUT(txl), .TX_LINE_OE_OUT(txoe), .RX_LINE_OWN_OUT(own),
		.SYNC_CLOCK_PIN_OUT(), .SYNC_CLOCK_PIN_OE_OUT());
	usr_line_peer usr_line_peer_inst (.clk_in(clk), .bit_clks_in(bclk), .frame_in(frm),
		.send_in(snd), .busy_out(busy), .line_out(rxl), .tx_line_in(txl), .tx_oe_in(txoe),
		.got_byte_out(gb), .got_count_out(gc));
	// free running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// address and data offered together, both released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do @(posedge clk); while (awr !== 1'b1);
		awv <= 1'b0;
		wv <= 1'b0;
		do @(posedge clk); while (bv !== 1'b1);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		ara <= a;
		arv <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		d = rdat;
		rs = rresp;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] rs;
		rd(a, d, rs);
		chk(d, exp);
	endtask
	// the peer reads frm bit by bit while it sends, so frm may not move meanwhile
	task automatic send(input logic [10:0] f);
		frm <= f;
		snd <= 1'b1;
		repeat (2) @(posedge clk);
		snd <= 1'b0;
		while (busy === 1'b1) @(posedge clk);
		repeat (4) @(posedge clk);
	endtask
	task automatic waitn(input int n);
		while (gc < n) @(posedge clk);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// cuts a hang short well after the tests should have ended
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		conclude();
	end
	initial begin
		{nrst, awv, wv, arv, gie, svc, snd} = 7'h00;
		{br, rr, ws, bclk} = {2'b11, 4'hF, 5'h10};
		{awa, ara, wd, frm} = {24'h0, 32'h0, 11'h7FF};
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rc(RA, 32'h20);
		rc(RB, 32'h00);
		rc(RC, 32'h06);
		rc(RD, 32'h00);
		rd(12'h3FC, v, r);
		chk({v, r}, 34'h2);
		foreach (modes[i]) begin
			wr(RC, modes[i]);
			rc(RC, modes[i]);
		end
		wr(RC, 32'h06);
		$display("test reset and modes done");
		wr(RB, 32'h08);
		wr(RD, 32'hA5);
		wr(RD, 32'h5A);
		wr(RD, 32'hFF);
		waitn(1);
		chk(gb, 8'hA5);
		waitn(2);
		chk(gb, 8'h5A);
		repeat (400) @(posedge clk);
		chk(gc, 8'h02);
		rc(RA, 32'h60);
		wr(RA, 32'h40);
		rc(RA, 32'h20);
		wr(RD, 32'hC3);
		wr(RB, 32'h00);
		chk(txoe, 1'b1);
		waitn(3);
		chk(gb, 8'hC3);
		repeat (40) @(posedge clk);
		chk(txoe, 1'b0);
		svc <= 1'b1;
		@(posedge clk);
		svc <= 1'b0;
		rc(RA, 32'h20);
		wr(RA, 32'h02);
		wr(RB, 32'h08);
		bclk <= 5'h08;
		wr(RD, 32'h96);
		waitn(4);
		chk(gb, 8'h96);
		bclk <= 5'h10;
		wr(RA, 32'h00);
		repeat (40) @(posedge clk);
		gie <= 1'b1;
		wr(RB, 32'hE8);
		chk({irq_txe, irq_txc}, 2'h3);
		gie <= 1'b0;
		@(posedge clk);
		chk({irq_txe, irq_txc}, 2'h0);
		wr(RA, 32'h40);
		$display("test transmit done");
		gie <= 1'b1;
		wr(RB, 32'h98);
		chk(own, 1'b1);
		send({2'b11, 8'h3C, 1'b0});
		send({2'b11, 8'h81, 1'b0});
		chk(irq_rx, 1'b1);
		rc(RA, 32'hA0);
		rc(RB, 32'h98);
		rc(RD, 32'h3C);
		rc(RD, 32'h81);
		rc(RA, 32'h20);
		send({2'b10, 8'h55, 1'b0});
		rc(RA, 32'hB0);
		rc(RD, 32'h55);
		wr(RC, 32'h26);
		send({2'b10, 8'h07, 1'b0});
		rc(RA, 32'hA4);
		rc(RD, 32'h07);
		wr(RC, 32'h00);
		send({2'b11, 8'hFF, 1'b0});
		rc(RD, 32'h1F);
		wr(RC, 32'h06);
		wr(RA, 32'h01);
		send({2'b11, 8'h12, 1'b0});
		send({2'b11, 8'h92, 1'b0});
		rc(RA, 32'hA1);
		rc(RD, 32'h92);
		wr(RA, 32'h00);
		foreach (ov[i]) send({2'b11, ov[i], 1'b0});
		rc(RD, 32'h11);
		dor = 1'b0;
		repeat (3) begin
			rd(RA, v, r);
			dor = dor | v[3];
			rd(RD, v, r);
		end
		chk(dor, 1'b1);
		send({2'b10, 8'h66, 1'b0});
		wr(RB, 32'h08);
		rc(RA, 32'h20);
		chk(own, 1'b0);
		wr(RB, 32'h0D);
		wr(RD, 32'h3C);
		waitn(5);
		chk(gb, 8'h3C);
		$display("test receive done");
		conclude();
	end
endmodule
`default_nettype wire

// *** usr_top_monitor.sv ***
// Purpose: port checker of the serial register block
// Assumes: one clock, reset asynchronous and active low
// Notes: byte addresses are the register index times four
`timescale 1ns/1ps
`default_nettype none
module usr_top_monitor (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	// register bus
	input wire logic [11:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	input wire logic S_AXI_AWREADY_OUT,
	input wire logic S_AXI_WVALID_IN,
	input wire logic S_AXI_BVALID_OUT,
	input wire logic [11:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	input wire logic S_AXI_ARREADY_OUT,
	input wire logic [31:0] S_AXI_RDATA_OUT,
	input wire logic [1:0] S_AXI_RRESP_OUT,
	input wire logic S_AXI_RVALID_OUT,
	// interrupts and pins
	input wire logic GLOBAL_IRQ_EN_IN,
	input wire logic RX_DONE_IRQ_OUT,
	input wire logic TX_DONE_IRQ_OUT,
	input wire logic TX_EMPTY_IRQ_OUT,
	input wire logic TX_LINE_OUT,
	input wire logic TX_LINE_OE_OUT,
	input wire logic RX_LINE_OWN_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	// taken requests, decoded by register index
	wire logic wr_take = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && S_AXI_AWREADY_OUT;
	wire logic rd_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
	wire logic [9:0] ridx = S_AXI_ARADDR_IN[11:2];
	wire logic b_wr = wr_take && (S_AXI_AWADDR_IN[11:2] == 10'h0C1);
	wire logic rd_bad = rd_take && !(ridx inside {10'h0C0, 10'h0C1, 10'h0C2, 10'h0C4, 10'h0C6});
	AST_WR_ANSWER: assert property (wr_take |=> S_AXI_BVALID_OUT)
		else $error("write not answered next cycle");
	AST_RD_ANSWER: assert property (rd_take |=> S_AXI_RVALID_OUT)
		else $error("read not answered next cycle");
	AST_UNMAPPED: assert property (rd_bad |=> S_AXI_RRESP_OUT == 2'h2 && S_AXI_RDATA_OUT == 32'h0)
		else $error("unmapped read not refused");
	AST_RXC_IRQ: assert property (RX_DONE_IRQ_OUT |-> GLOBAL_IRQ_EN_IN)
		else $error("receive irq without global enable");
	AST_TXC_IRQ: assert property (TX_DONE_IRQ_OUT |-> GLOBAL_IRQ_EN_IN)
		else $error("transmit done irq without global enable");
	AST_TXE_IRQ: assert property (TX_EMPTY_IRQ_OUT |-> GLOBAL_IRQ_EN_IN)
		else $error("buffer empty irq without global enable");
	AST_RX_OWN: assert property (!b_wr |=> $stable(RX_LINE_OWN_OUT))
		else $error("receive pin ownership moved without a control write");
	// a low bit lasts at least eight clocks at the fastest asynchronous rate
	AST_LOW_BIT: assert property ($fell(TX_LINE_OUT) && TX_LINE_OE_OUT |=> !TX_LINE_OUT [*7])
		else $error("transmit low bit too short");
	AST_TX_RELEASE: assert property ($fell(TX_LINE_OE_OUT) |-> $past(TX_LINE_OUT) && $past(TX_LINE_OUT, 4))
		else $error("transmit pin released inside a frame");
endmodule
bind usr_top usr_top_monitor usr_top_monitor_inst (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
	.S_AXI_AWADDR_IN(S_AXI_AWADDR_IN), .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN),
	.S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT), .S_AXI_WVALID_IN(S_AXI_WVALID_IN),
	.S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN),
	.S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
	.S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RRESP_OUT(S_AXI_RRESP_OUT),
	.S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN),
	.RX_DONE_IRQ_OUT(RX_DONE_IRQ_OUT), .TX_DONE_IRQ_OUT(TX_DONE_IRQ_OUT),
	.TX_EMPTY_IRQ_OUT(TX_EMPTY_IRQ_OUT), .TX_LINE_OUT(TX_LINE_OUT),
	.TX_LINE_OE_OUT(TX_LINE_OE_OUT), .RX_LINE_OWN_OUT(RX_LINE_OWN_OUT));
`default_nettype wire
